// *** bench/plca_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// link peer: answers the init return with its own buffer credits
module plca_peer #(
  parameter logic [7:0] C0 = 8'h04,
  parameter logic [7:0] C1 = 8'h00,
  parameter logic [7:0] CA = 8'h02
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       ret_vld,
  input wire logic [1:0] ret_ch,
  output logic           peer_cred_vld,
  output logic     [1:0] peer_cred_ch,
  output logic     [7:0] peer_cred_cnt
);
  logic [7:0] lim;
  // own limit for the channel just returned
  always_comb lim = (ret_ch == 2'h0) ? C0 : (ret_ch == 2'h1) ? C1 : CA;
  // one answer per channel; zero keeps the channel shut, idle lines toggle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      peer_cred_vld <= 1'b0;
      peer_cred_ch  <= 2'h0;
      peer_cred_cnt <= 8'h00;
    end else begin
      peer_cred_vld <= ret_vld && (lim != 8'h00);
      peer_cred_ch  <= ret_vld ? ret_ch : ~peer_cred_ch;
      peer_cred_cnt <= ret_vld ? lim : ~peer_cred_cnt;
    end
  end
endmodule
`default_nettype wire

// *** bench/plca_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// register, request and link sequences
module plca_top_test;
  import plca_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, req_vld = 1'b0, req_coh = 1'b0;
  logic [4:0]  req_home_node = 5'h00, req_home_eff;
  logic [19:0] req_pa = 20'h0;
  logic        req_grant, req_stall, req_refuse, peer_cred_vld, ret_vld;
  logic [2:0]  req_txn_node, tx_ready, cmp_pool = 3'h0;
  logic [5:0]  req_tid, cmp_tid = 6'h0;
  logic        cmp_vld = 1'b0, cmp_coh = 1'b0, tx_vld = 1'b0;
  logic [1:0]  peer_cred_ch, ret_ch, tx_ch = 2'h0;
  logic [7:0]  peer_cred_cnt, ret_cnt;
  int          n_fail = 0, total_checks = 0;
  logic [5:0]  ent [6] = '{6'h20, 6'h30, 6'h18, 6'h10, 6'h18, 6'h20};
  logic [5:0]  hemi = 6'b110011;
  logic [4:0]  homes [4] = '{5'h06, 5'h12, 5'h1b, 5'h01};
  logic [7:0]  lb [3] = '{8'h05, 8'h02, 8'h03};

  plca_top i_dut (.*);
  plca_peer i_peer (.*);

  // 10 MHz clock
  always #50 clk = ~clk;

  // ==========================================
  // bus tasks and compare
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // request pulse; outcome {grant, stall, refuse} read in the answer cycle
  task automatic rq(input logic c, input logic [4:0] h, input logic [19:0] pa,
                    input logic [2:0] e);
    @(posedge clk);
    req_vld      <= 1'b1;
    req_coh      <= c;
    req_home_node <= h;
    req_pa       <= pa;
    @(posedge clk);
    req_vld <= 1'b0;
    #1;
    chk("outcome", {req_grant, req_stall, req_refuse}, e);
  endtask
  task automatic cp(input logic [2:0] p, input logic [5:0] r);
    @(posedge clk);
    cmp_vld  <= 1'b1;
    cmp_coh  <= 1'b1;
    cmp_pool <= p;
    cmp_tid  <= r;
    @(posedge clk);
    cmp_vld <= 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================
  // test sequence
  initial begin
    logic [31:0] d;
    logic [4:0]  h;
    int          i;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    wr(NC_LIM_OFS, 32'hc);
    for (i = 0; i < 6; i++) begin
      wr(CTRL_OFS, 32'(i));
      rd(STAT_OFS, d);
      chk("status", d[6:0], {hemi[i], ent[i]});
    end
    wr(CTRL_OFS, 32'h6);
    rd(CTRL_OFS, d);
    chk("mode", d[2:0], 3'h5);
    wr(TID_OFS, 32'h600);
    rd(TID_OFS, d);
    chk("freelist", d[11:0], 12'h600);
    $display("modes done");
    wr(CTRL_OFS, 32'h2);
    wr(TID_OFS, 32'h404);
    for (i = 0; i < 4; i++) begin
      h = homes[i];
      rq(1'b1, h, 20'h0, 3'b100);
      chk("pool", req_txn_node, {h[3:2], h[1] ^ h[4]});
      chk("id", req_tid, 6'(4 + i));
    end
    rq(1'b1, 5'h06, 20'h0, 3'b010);
    cp(3'h0, 6'h05);
    wr(COH_LIM_OFS, 32'h1);
    rq(1'b1, 5'h06, 20'h0, 3'b010);
    cp(3'h3, 6'h04);
    rq(1'b1, 5'h06, 20'h0, 3'b100);
    chk("id", req_tid, 6'h04);
    wr(NC_LIM_OFS, 32'h1);
    rq(1'b0, 5'h03, 20'h0, 3'b100);
    rq(1'b0, 5'h1c, 20'h0, 3'b010);
    $display("pools done");
    wr(COH_LIM_OFS, 32'h10);
    wr(TID_OFS, 32'hc00);
    wr(CTRL_OFS, 32'h10);
    rq(1'b1, 5'h00, 20'h82000, 3'b001);
    rq(1'b1, 5'h00, 20'h82400, 3'b100);
    chk("home", req_home_eff, 5'h02);
    chk("pool", req_txn_node, 3'h1);
    $display("hemisphere done");
    wr(LBUF_OFS, 32'h30205);
    wr(CTRL_OFS, 32'h18);
    for (i = 0; i < 8 && ret_vld !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    for (i = 0; i < 3; i++) begin
      chk("return", {ret_vld, ret_ch, ret_cnt}, {1'b1, 2'(i), lb[i]});
      @(posedge clk);
      #1;
    end
    repeat (3) @(posedge clk);
    #1;
    chk("ready", tx_ready, 3'b101);
    @(posedge clk);
    tx_vld <= 1'b1;
    tx_ch  <= 2'h2;
    repeat (2) @(posedge clk);
    tx_ch <= 2'h1;
    @(posedge clk);
    tx_ch <= 2'h0;
    @(posedge clk);
    tx_vld <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("ready", tx_ready, 3'b001);
    rd(LCRED_OFS, d);
    chk("credits", d[23:0], 24'h000003);
    $display("link done");
    finish_test();
  end

  // watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #1000000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire

// *** shared/plca_pkg.sv ***
`default_nettype none
// =====================================================================
// shared constants for the credit and transaction-id allocator
package plca_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] COH_LIM_OFS = 8'h04;
  localparam logic [7:0] NC_LIM_OFS  = 8'h08;
  localparam logic [7:0] TID_OFS     = 8'h0c;
  localparam logic [7:0] LBUF_OFS    = 8'h10;
  localparam logic [7:0] STAT_OFS    = 8'h14;
  localparam logic [7:0] LCRED_OFS   = 8'h18;
  localparam logic [7:0] AVAIL_OFS   = 8'h1c;
  // field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_INIT_BIT  = 3;
  localparam int CTRL_CANID_BIT = 4;
  localparam int TID_BASE_LSB   = 0;
  localparam int TID_LEN_LSB    = 8;
  localparam int STAT_HEMI_BIT  = 6;
  localparam int AVAIL_NC_BIT   = 8;
  localparam int AVAIL_BUSY_LSB = 16;
  // physical address bits hashed into the caching agent bit
  localparam int PA_H0 = 19;
  localparam int PA_H1 = 13;
  localparam int PA_H2 = 10;
  localparam int PA_H3 = 6;
  // sizes
  localparam int NODE_W = 5;
  localparam int PA_W   = 20;
  localparam int TID_W  = 6;
  localparam int FL_MAX = 12;
  localparam int FL_W   = 4;
  localparam int CRED_W = 8;
  // reset values and mode limit
  localparam logic [2:0]        MODE_RST    = 3'h0;
  localparam logic [2:0]        MODE_MAX    = 3'h5;
  localparam logic [7:0]        COH_LIM_RST = 8'h10;
  localparam logic [7:0]        NC_LIM_RST  = 8'h08;
  localparam logic [TID_W-1:0]  TID_BASE_RST  = 6'h00;
  localparam logic [FL_W-1:0]   TID_LEN_RST   = 4'hc;
  localparam logic [23:0]       LBUF_RST    = 24'h040404;
  // link channel codes
  localparam logic [1:0] CH_DF0 = 2'h0;
  localparam logic [1:0] CH_DF1 = 2'h1;
  localparam logic [1:0] CH_ADP = 2'h2;

  typedef enum logic [2:0] {
    PLCA_IDLE    = 3'b001,
    PLCA_RET_ALT = 3'b010,
    PLCA_RET_ADP = 3'b100
  } plca_ret_e;

  // coherent pool from home node identifier
  function automatic logic [2:0] plca_pool_idx(input logic [NODE_W-1:0] node);
    return {node[3:2], node[1] ^ node[4]};
  endfunction

  // hemisphere partitions of the home tracker
  function automatic logic plca_hemi(input logic [2:0] mode);
    return (mode == 3'h0) || (mode == 3'h1) || (mode == 3'h4) || (mode == 3'h5);
  endfunction

  // tracker entries per caching agent for each partition
  function automatic logic [5:0] plca_ca_entries(input logic [2:0] mode);
    case (mode)
      3'h0: return 6'h20;
      3'h1: return 6'h30;
      3'h2: return 6'h18;
      3'h3: return 6'h10;
      3'h4: return 6'h18;
      3'h5: return 6'h20;
      default: return 6'h00;
    endcase
  endfunction

  // lowest free freelist slot, msb flags a hit
  function automatic logic [FL_W:0] plca_first_free(input logic [FL_MAX-1:0] v);
    logic [FL_W:0] r;
    r = '0;
    for (int i = FL_MAX - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, FL_W'(i)};
      end
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// *** shared/plca_pool_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// credit pool bank handshake
interface plca_pool_if #(parameter int N = 8, parameter int W = 8);
  logic [N-1:0] take;
  logic [N-1:0] give;
  logic [N-1:0] avail;
  logic [W-1:0] limit;
  modport ctl  (output take, output give, output limit, input avail);
  modport bank (input take, input give, input limit, output avail);
endinterface
`default_nettype wire

// *** src/plca_link.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// link credit counters and init-time credit return
module plca_link #(
  parameter int W = 8
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              init,
  input wire logic [3*W-1:0]    lbuf,
  input wire logic              peer_vld,
  input wire logic [1:0]        peer_ch,
  input wire logic [W-1:0]      peer_cnt,
  input wire logic              send_vld,
  input wire logic [1:0]        send_ch,
  output logic     [2:0]        ok,
  output logic     [3*W-1:0]    cred,
  output logic                  ret_vld,
  output logic     [1:0]        ret_ch,
  output logic     [W-1:0]      ret_cnt
);
  import plca_pkg::*;

  plca_ret_e      st_reg;
  plca_ret_e      st_next;
  logic [3*W-1:0] cred_next;
  logic [2:0]     ok_next;
  logic           ret_vld_next;
  logic [1:0]     ret_ch_next;
  logic [W-1:0]   ret_cnt_next;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // =====================================================================
  // credit counts: deadlock-free channels in messages, adaptive in flits
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      if (init) begin
        cred_next[c*W +: W] = '0;
      end else begin
        cred_next[c*W +: W] = cred[c*W +: W]
          + ((peer_vld && peer_ch == 2'(c)) ? peer_cnt : '0)
          - W'(send_vld && send_ch == 2'(c) && ok[c]);
      end
      ok_next[c] = cred_next[c*W +: W] != '0;
    end
  end

  // =====================================================================
  // return own buffer limit per channel, one channel per cycle
  always_comb begin
    st_next      = st_reg;
    ret_vld_next = 1'b0;
    ret_ch_next  = CH_DF0;
    ret_cnt_next = '0;
    case (st_reg)
      PLCA_IDLE: begin
        if (init) begin
          ret_vld_next = 1'b1;
          ret_cnt_next = lbuf[0 +: W];
          st_next      = PLCA_RET_ALT;
        end
      end
      PLCA_RET_ALT: begin
        ret_vld_next = 1'b1;
        ret_ch_next  = CH_DF1;
        ret_cnt_next = lbuf[W +: W];
        st_next      = PLCA_RET_ADP;
      end
      PLCA_RET_ADP: begin
        ret_vld_next = 1'b1;
        ret_ch_next  = CH_ADP;
        ret_cnt_next = lbuf[2*W +: W];
        st_next      = PLCA_IDLE;
      end
      default: st_next = PLCA_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg  <= PLCA_IDLE;
      cred    <= '0;
      ok      <= '0;
      ret_vld <= 1'b0;
      ret_ch  <= CH_DF0;
      ret_cnt <= '0;
    end else begin
      st_reg  <= st_next;
      cred    <= cred_next;
      ok      <= ok_next;
      ret_vld <= ret_vld_next;
      ret_ch  <= ret_ch_next;
      ret_cnt <= ret_cnt_next;
    end
  end

  init_clear_a : assert property (init |=> cred == '0)
    else $error("credits not cleared at link init");
  ret_seq_a : assert property ((init && st_reg == PLCA_IDLE) |=>
      (ret_vld && ret_ch == CH_DF0) ##1 (ret_vld && ret_ch == CH_DF1)
      ##1 (ret_vld && ret_ch == CH_ADP))
    else $error("credit return sequence wrong");
  send_dec_a : assert property ((send_vld && send_ch == CH_DF0 && !peer_vld && !init)
      |=> cred[0 +: W] == ($past(cred[0 +: W]) - W'($past(ok[0]))))
    else $error("vn0 credit not spent on send");
endmodule
`default_nettype wire

// *** src/plca_pool.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// bank of outstanding-request counters, one per pool
module plca_pool #(
  parameter int N = 8,
  parameter int W = 8
) (
  input wire logic   clk,
  input wire logic   rst_b,
  plca_pool_if.bank  pif
);
  import plca_pkg::*;

  logic [W-1:0] cnt_reg  [N];
  logic [W-1:0] cnt_next [N];

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // count up on take, down on give; same cycle nets out unless the count is zero
  always_comb begin
    for (int i = 0; i < N; i++) begin
      cnt_next[i] = cnt_reg[i] + W'(pif.take[i])
                    - W'(pif.give[i] && (cnt_reg[i] != '0));
      pif.avail[i] = cnt_reg[i] < pif.limit;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < N; i++) begin
        cnt_reg[i] <= '0;
      end
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  for (genvar g = 0; g < N; g++) begin : g_chk
    pool_limit_a : assert property (pif.take[g] |-> cnt_reg[g] < pif.limit)
      else $error("request taken from a full pool");
  end
endmodule
`default_nettype wire

// *** src/plca_top.sv ***
// Contract
// - coherent pool from home bits 3:2, 1^4
// - pool index forms transaction node identifier
// - never exceed target tracker entries per pool
// - non-home requests may be stalled, not sunk
// - one non-coherent pool for all targets
// - six tracker partition modes, 0 to 5
// - transaction id is base plus first free slot
// - hemisphere: home bit 1 xor address hash
// - hemisphere: only matching caching agent issues
// - link credits set before init, per unit
// - init returns buffer credits; zero disables channel
`timescale 1ns/1ps
`default_nettype none
module plca_top (
  input wire logic                            clk,
  input wire logic                            rst_b,
  input wire logic [7:0]                      reg_addr,
  input wire logic [31:0]                     reg_wdata,
  input wire logic                            reg_wr,
  input wire logic                            reg_rd,
  output logic     [31:0]                     reg_rdata,
  input wire logic                            req_vld,
  input wire logic                            req_coh,
  input wire logic [plca_pkg::NODE_W-1:0]     req_home_node,
  input wire logic [plca_pkg::PA_W-1:0]       req_pa,
  output logic                                req_grant,
  output logic                                req_stall,
  output logic                                req_refuse,
  output logic     [2:0]                      req_txn_node,
  output logic     [plca_pkg::NODE_W-1:0]     req_home_eff,
  output logic     [plca_pkg::TID_W-1:0]      req_tid,
  input wire logic                            cmp_vld,
  input wire logic                            cmp_coh,
  input wire logic [2:0]                      cmp_pool,
  input wire logic [plca_pkg::TID_W-1:0]      cmp_tid,
  input wire logic                            peer_cred_vld,
  input wire logic [1:0]                      peer_cred_ch,
  input wire logic [plca_pkg::CRED_W-1:0]     peer_cred_cnt,
  input wire logic                            tx_vld,
  input wire logic [1:0]                      tx_ch,
  output logic     [2:0]                      tx_ready,
  output logic                                ret_vld,
  output logic     [1:0]                      ret_ch,
  output logic     [plca_pkg::CRED_W-1:0]     ret_cnt
);
  import plca_pkg::*;

  // =====================================================================
  // configuration state
  logic [2:0]        mode_reg;
  logic [2:0]        mode_next;
  logic              canid_reg;
  logic              canid_next;
  logic              init_reg;
  logic              init_next;
  logic [7:0]        coh_lim_reg;
  logic [7:0]        coh_lim_next;
  logic [7:0]        nc_lim_reg;
  logic [7:0]        nc_lim_next;
  logic [TID_W-1:0]  tid_base_reg;
  logic [TID_W-1:0]  tid_base_next;
  logic [FL_W-1:0]   tid_len_reg;
  logic [FL_W-1:0]   tid_len_next;
  logic [23:0]       lbuf_reg;
  logic [23:0]       lbuf_next;
  logic [31:0]       rdata_next;

  // request path state
  logic              grant_next;
  logic              stall_next;
  logic              refuse_next;
  logic [2:0]        txn_node_next;
  logic [NODE_W-1:0] home_eff_next;
  logic [TID_W-1:0]  tid_next;
  logic              coh_q_reg;
  logic              coh_q_next;
  logic [FL_MAX-1:0] busy_reg;
  logic [FL_MAX-1:0] busy_next;

  // combinational helpers
  logic              hemi;
  logic              pa_hash;
  logic [NODE_W-1:0] home_eff;
  logic [2:0]        pool;
  logic [FL_MAX-1:0] len_mask;
  logic [FL_W:0]     pick;
  logic [TID_W-1:0]  rel_off;
  logic [3*CRED_W-1:0] lcred;

  plca_pool_if #(.N(8), .W(8)) coh_if ();
  plca_pool_if #(.N(1), .W(8)) nc_if ();

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // =====================================================================
  // register writes
  always_comb begin
    mode_next      = mode_reg;
    canid_next     = canid_reg;
    init_next      = 1'b0;
    coh_lim_next   = coh_lim_reg;
    nc_lim_next    = nc_lim_reg;
    tid_base_next  = tid_base_reg;
    tid_len_next   = tid_len_reg;
    lbuf_next      = lbuf_reg;
    if (reg_wr) begin
      case (reg_addr)
        CTRL_OFS: begin
          if (reg_wdata[CTRL_MODE_LSB +: 3] <= MODE_MAX) begin
            mode_next = reg_wdata[CTRL_MODE_LSB +: 3];
          end
          init_next  = reg_wdata[CTRL_INIT_BIT];
          canid_next = reg_wdata[CTRL_CANID_BIT];
        end
        COH_LIM_OFS: coh_lim_next = reg_wdata[7:0];
        NC_LIM_OFS:  nc_lim_next  = reg_wdata[7:0];
        TID_OFS: begin
          tid_base_next = reg_wdata[TID_BASE_LSB +: TID_W];
          if (reg_wdata[TID_LEN_LSB +: FL_W] <= FL_W'(FL_MAX)) begin
            tid_len_next = reg_wdata[TID_LEN_LSB +: FL_W];
          end
        end
        LBUF_OFS: lbuf_next = reg_wdata[23:0];
        default: ;
      endcase
    end
  end

  // =====================================================================
  // register reads, data valid only in the cycle after the strobe
  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      case (reg_addr)
        CTRL_OFS: begin
          rdata_next[CTRL_MODE_LSB +: 3] = mode_reg;
          rdata_next[CTRL_CANID_BIT]     = canid_reg;
        end
        COH_LIM_OFS: rdata_next[7:0] = coh_lim_reg;
        NC_LIM_OFS:  rdata_next[7:0] = nc_lim_reg;
        TID_OFS: begin
          rdata_next[TID_BASE_LSB +: TID_W] = tid_base_reg;
          rdata_next[TID_LEN_LSB +: FL_W]   = tid_len_reg;
        end
        LBUF_OFS: rdata_next[23:0] = lbuf_reg;
        STAT_OFS: begin
          rdata_next[5:0]           = plca_ca_entries(mode_reg);
          rdata_next[STAT_HEMI_BIT] = hemi;
        end
        LCRED_OFS: rdata_next[23:0] = lcred;
        AVAIL_OFS: begin
          rdata_next[7:0]                           = coh_if.avail;
          rdata_next[AVAIL_NC_BIT]                  = nc_if.avail[0];
          rdata_next[AVAIL_BUSY_LSB +: FL_MAX]      = busy_reg;
        end
        default: rdata_next = '0;
      endcase
    end
  end

  // =====================================================================
  // home mapping and pool selection
  always_comb begin
    hemi     = plca_hemi(mode_reg);
    pa_hash  = req_pa[PA_H0] ^ req_pa[PA_H1] ^ req_pa[PA_H2] ^ req_pa[PA_H3];
    home_eff = req_home_node;
    if (hemi) begin
      home_eff[1] = req_home_node[1] ^ pa_hash;
    end
    pool = plca_pool_idx(home_eff);
  end

  // =====================================================================
  // freelist of transaction ids for this cache box
  always_comb begin
    for (int i = 0; i < FL_MAX; i++) begin
      len_mask[i] = FL_W'(i) < tid_len_reg;
    end
    pick    = plca_first_free(~busy_reg & len_mask);
    rel_off = cmp_tid - tid_base_reg;
  end

  // =====================================================================
  // request decision: one of grant, stall or refuse per request
  always_comb begin
    grant_next    = 1'b0;
    stall_next    = 1'b0;
    refuse_next   = 1'b0;
    coh_q_next    = req_coh;
    txn_node_next = req_txn_node;
    home_eff_next = req_home_eff;
    tid_next      = req_tid;
    busy_next     = busy_reg;
    coh_if.take   = '0;
    nc_if.take    = '0;
    if (cmp_vld && cmp_coh && (rel_off < TID_W'(FL_MAX))) begin
      busy_next[rel_off[FL_W-1:0]] = 1'b0;
    end
    if (req_vld && req_coh) begin
      if (hemi && (pa_hash != canid_reg)) begin
        refuse_next = 1'b1;
      end else if (coh_if.avail[pool] && pick[FL_W]) begin
        grant_next        = 1'b1;
        coh_if.take[pool] = 1'b1;
        txn_node_next     = pool;
        home_eff_next     = home_eff;
        tid_next          = tid_base_reg + TID_W'(pick[FL_W-1:0]);
        busy_next[pick[FL_W-1:0]] = 1'b1;
      end else begin
        stall_next = 1'b1;
      end
    end else if (req_vld) begin
      if (nc_if.avail[0]) begin
        grant_next    = 1'b1;
        nc_if.take[0] = 1'b1;
        home_eff_next = req_home_node;
        tid_next      = '0;
      end else begin
        stall_next = 1'b1;
      end
    end
  end

  // =====================================================================
  // credit return into the pools
  always_comb begin
    coh_if.limit = coh_lim_reg;
    nc_if.limit  = nc_lim_reg;
    coh_if.give  = '0;
    nc_if.give   = '0;
    if (cmp_vld && cmp_coh) begin
      coh_if.give[cmp_pool] = 1'b1;
    end
    if (cmp_vld && !cmp_coh) begin
      nc_if.give[0] = 1'b1;
    end
  end

  // =====================================================================
  // state registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg      <= MODE_RST;
      canid_reg     <= 1'b0;
      init_reg      <= 1'b0;
      coh_lim_reg   <= COH_LIM_RST;
      nc_lim_reg    <= NC_LIM_RST;
      tid_base_reg  <= TID_BASE_RST;
      tid_len_reg   <= TID_LEN_RST;
      lbuf_reg      <= LBUF_RST;
      reg_rdata     <= '0;
      req_grant     <= 1'b0;
      req_stall     <= 1'b0;
      req_refuse    <= 1'b0;
      req_txn_node  <= '0;
      req_home_eff  <= '0;
      req_tid       <= '0;
      coh_q_reg     <= 1'b0;
      busy_reg      <= '0;
    end else begin
      mode_reg      <= mode_next;
      canid_reg     <= canid_next;
      init_reg      <= init_next;
      coh_lim_reg   <= coh_lim_next;
      nc_lim_reg    <= nc_lim_next;
      tid_base_reg  <= tid_base_next;
      tid_len_reg   <= tid_len_next;
      lbuf_reg      <= lbuf_next;
      reg_rdata     <= rdata_next;
      req_grant     <= grant_next;
      req_stall     <= stall_next;
      req_refuse    <= refuse_next;
      req_txn_node  <= txn_node_next;
      req_home_eff  <= home_eff_next;
      req_tid       <= tid_next;
      coh_q_reg     <= coh_q_next;
      busy_reg      <= busy_next;
    end
  end

  // =====================================================================
  // pools and link
  plca_pool #(.N(8), .W(8)) u_coh (
    .clk   (clk),
    .rst_b (rst_b),
    .pif   (coh_if.bank)
  );

  plca_pool #(.N(1), .W(8)) u_nc (
    .clk   (clk),
    .rst_b (rst_b),
    .pif   (nc_if.bank)
  );

  plca_link #(.W(CRED_W)) u_link (
    .clk      (clk),
    .rst_b    (rst_b),
    .init     (init_reg),
    .lbuf     (lbuf_reg),
    .peer_vld (peer_cred_vld),
    .peer_ch  (peer_cred_ch),
    .peer_cnt (peer_cred_cnt),
    .send_vld (tx_vld),
    .send_ch  (tx_ch),
    .ok       (tx_ready),
    .cred     (lcred),
    .ret_vld  (ret_vld),
    .ret_ch   (ret_ch),
    .ret_cnt  (ret_cnt)
  );

  // =====================================================================
  // checks
  pool_sel_a : assert property ((req_vld && req_coh && !hemi) ##1 req_grant |->
      req_txn_node == {$past(req_home_node[3:2]), $past(req_home_node[1] ^ req_home_node[4])})
    else $error("coherent pool index wrong");
  txn_node_a : assert property ((req_grant && coh_q_reg) |->
      req_txn_node == plca_pool_idx(req_home_eff))
    else $error("transaction node id not from pool");
  nc_stall_a : assert property ((req_vld && !req_coh && !nc_if.avail[0]) |=>
      req_stall && !req_grant)
    else $error("non-coherent request not stalled");
  mode_legal_a : assert property (mode_reg <= MODE_MAX)
    else $error("tracker mode out of range");
  tid_range_a : assert property ((req_grant && coh_q_reg) |->
      (req_tid - tid_base_reg) < {2'b00, tid_len_reg})
    else $error("transaction id outside freelist");
  hemi_xor_a : assert property ((req_vld && req_coh && hemi) ##1 req_grant |->
      req_home_eff[1] == ($past(req_home_node[1]) ^ $past(pa_hash)))
    else $error("hemisphere home bit wrong");
  hemi_refuse_a : assert property ((req_vld && req_coh && hemi && pa_hash != canid_reg)
      |=> req_refuse && !req_grant)
    else $error("foreign hemisphere request not refused");
  one_answer_a : assert property (req_vld |=>
      (req_grant + req_stall + req_refuse) == 2'd1)
    else $error("request needs exactly one answer");
endmodule
`default_nettype wire
